/* design/tmz_pkg.sv */
// Purpose: Constants for the eight-bit timer with prescaler
// Assumes: Register port with byte-wide registers at chosen indices
// Notes:   Option and interrupt bit positions follow the register layouts
`default_nettype none
package tmz_pkg;
   // Register indices
   localparam logic [1:0] ADDR_COUNT  = 2'h0;
   localparam logic [1:0] ADDR_OPTION = 2'h1;
   localparam logic [1:0] ADDR_INTCTL = 2'h2;
   // Option register fields
   localparam int OPT_PULLUP_DIS = 7;
   localparam int OPT_IRQ_EDGE   = 6;
   localparam int OPT_SRC_SEL    = 5;
   localparam int OPT_EDGE_SEL   = 4;
   localparam int OPT_PS_BYPASS  = 3;
   localparam int OPT_RATE_HI    = 2;
   // Interrupt control fields
   localparam int INT_GLOBAL_EN  = 7;
   localparam int INT_PERIPH_EN  = 6;
   localparam int INT_OVF_EN     = 5;
   localparam int INT_OVF_FLAG   = 2;
   // Reset values and instruction clock divide
   localparam logic [7:0] OPTION_RST = 8'hff;
   localparam logic [7:0] INTCTL_RST = 8'h00;
   localparam logic [7:0] COUNT_RST  = 8'h00;
   localparam int INSTR_DIV = 4;
endpackage
`default_nettype wire

/* design/tmz_tick_if.sv */
// Purpose: Carries count ticks from the prescaler into the counter
// Assumes: Single clock domain
// Notes:   Tick is a one-cycle pulse
`default_nettype none
interface tmz_tick_if;
   logic       src_tick;
   logic       bypass;
   logic [2:0] rate;
   logic       clear;
   logic       out_tick;
   modport ctl (output src_tick, output bypass, output rate, output clear, input out_tick);
   modport pre (input src_tick, input bypass, input rate, input clear, output out_tick);
endinterface
`default_nettype wire

/* design/tmz_prescaler.sv */
// Purpose: Divides source ticks by 2 to 256 or passes them straight
// Assumes: Ticks are one-cycle pulses on clk_sys_i
// Notes:   Prescale count clears on a counter write
`default_nettype none
module tmz_prescaler (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_b_i,
   // Tick path
   tmz_tick_if.pre   tk
);
   typedef struct packed {
      logic [7:0] div;
      logic       tick;
   } tmz_pre_state_type;
   tmz_pre_state_type st_reg;
   tmz_pre_state_type st_next;
   logic [7:0]        limit;

   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      limit        = 8'((9'h002 << tk.rate) - 9'h001);
      if (tk.clear) begin
         st_next.div = 8'h00;
      end else if (tk.src_tick) begin
         if (tk.bypass) begin
            st_next.tick = 1'b1;
         end else if (st_reg.div >= limit) begin
            st_next.div  = 8'h00;
            st_next.tick = 1'b1;
         end else begin
            st_next.div = st_reg.div + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign tk.out_tick = st_reg.tick;

   property p_bypass_pass;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (tk.src_tick && tk.bypass && !tk.clear) |=> tk.out_tick;
   endproperty
   a_bypass_pass: assert property (p_bypass_pass)
      else $error("bypassed tick not passed");

   property p_div2;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (tk.out_tick && !tk.bypass && tk.rate == 3'h0) |-> !$past(tk.out_tick);
   endproperty
   a_div2: assert property (p_div2)
      else $error("divide by two too fast");
endmodule
`default_nettype wire

/* design/tmz_timer.sv */
// Purpose: Eight-bit timer/counter with prescaler and register port
// Assumes: Read data valid the cycle after the read strobe
// Notes:   Instruction clock is clk_sys_i divided by four
`default_nettype none
module tmz_timer (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_b_i,
   // Register port
   input  wire logic [1:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // Pins
   input  wire logic       ext_count_pin_i,
   input  wire logic       master_clear_reset_i,
   output logic            master_clear_pullup_o,
   output logic            pullup_enable_o,
   // Events
   output logic            overflow_irq_o
);
   typedef struct packed {
      logic [7:0] count_value;
      logic [7:0] option;
      logic [7:0] intctl;
      logic [1:0] idiv;
      logic       pin_s1;
      logic       pin_s2;
      logic       pin_s3;
      logic [7:0] rdata;
      logic       irq;
      logic       master_clear_pu;
      logic       pu_en;
   } tmz_state_type;

   tmz_state_type st_reg;
   tmz_state_type st_next;
   tmz_tick_if    tk ();
   logic          pin_rise;
   logic          pin_fall;
   logic          instr_tick;
   logic          wrap;

   tmz_prescaler u_pre (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .tk        (tk)
   );

   always_comb begin
      st_next        = st_reg;
      st_next.pin_s1 = ext_count_pin_i;
      st_next.pin_s2 = st_reg.pin_s1;
      st_next.pin_s3 = st_reg.pin_s2;
      pin_rise       = st_reg.pin_s2 && !st_reg.pin_s3;
      pin_fall       = !st_reg.pin_s2 && st_reg.pin_s3;
      instr_tick     = (st_reg.idiv == 2'(tmz_pkg::INSTR_DIV - 1));
      st_next.idiv   = st_reg.idiv + 2'h1;
      // Source and edge choice
      if (st_reg.option[tmz_pkg::OPT_SRC_SEL]) begin
         tk.src_tick = st_reg.option[tmz_pkg::OPT_EDGE_SEL] ? pin_fall : pin_rise;
      end else begin
         tk.src_tick = instr_tick;
      end
      tk.bypass = st_reg.option[tmz_pkg::OPT_PS_BYPASS];
      tk.rate   = st_reg.option[tmz_pkg::OPT_RATE_HI:0];
      tk.clear  = reg_wr_i && reg_addr_i == tmz_pkg::ADDR_COUNT;
      wrap      = tk.out_tick && st_reg.count_value == 8'hff;
      if (tk.out_tick) begin
         st_next.count_value = st_reg.count_value + 8'h01;
      end
      // Register writes
      if (reg_wr_i) begin
         if (reg_addr_i == tmz_pkg::ADDR_COUNT) begin
            st_next.count_value = reg_wdata_i;
         end else if (reg_addr_i == tmz_pkg::ADDR_OPTION) begin
            st_next.option = reg_wdata_i;
         end else if (reg_addr_i == tmz_pkg::ADDR_INTCTL) begin
            st_next.intctl = reg_wdata_i;
         end
      end
      // Overflow set wins over a clearing write
      if (wrap && !tk.clear) begin
         st_next.intctl[tmz_pkg::INT_OVF_FLAG] = 1'b1;
      end
      st_next.irq = st_next.intctl[tmz_pkg::INT_OVF_FLAG]
                    && st_next.intctl[tmz_pkg::INT_OVF_EN];
      st_next.pu_en   = !st_next.option[tmz_pkg::OPT_PULLUP_DIS];
      st_next.master_clear_pu = master_clear_reset_i || st_next.pu_en;
      // Register reads
      st_next.rdata = 8'h00;
      if (reg_rd_i) begin
         if (reg_addr_i == tmz_pkg::ADDR_COUNT) begin
            st_next.rdata = st_reg.count_value;
         end else if (reg_addr_i == tmz_pkg::ADDR_OPTION) begin
            st_next.rdata = st_reg.option;
         end else if (reg_addr_i == tmz_pkg::ADDR_INTCTL) begin
            st_next.rdata = st_reg.intctl;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg             <= '0;
         st_reg.option      <= tmz_pkg::OPTION_RST;
         st_reg.intctl      <= tmz_pkg::INTCTL_RST;
         st_reg.count_value <= tmz_pkg::COUNT_RST;
         st_reg.master_clear_pu <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata_o           = st_reg.rdata;
   assign overflow_irq_o        = st_reg.irq;
   assign master_clear_pullup_o = st_reg.master_clear_pu;
   assign pullup_enable_o       = st_reg.pu_en;

   // Counting path, interrupt and pull-up checks
   property p_src_instr;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (!st_reg.option[tmz_pkg::OPT_SRC_SEL] && tk.src_tick) |-> st_reg.idiv == 2'h3;
   endproperty
   a_src_instr: assert property (p_src_instr)
      else $error("instruction tick off phase");

   property p_src_pin;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (st_reg.option[tmz_pkg::OPT_SRC_SEL] && tk.src_tick)
      |-> st_reg.pin_s2 != st_reg.pin_s3;
   endproperty
   a_src_pin: assert property (p_src_pin)
      else $error("pin tick without pin edge");

   property p_edge_sel;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (st_reg.option[tmz_pkg::OPT_SRC_SEL] && st_reg.option[tmz_pkg::OPT_EDGE_SEL]
       && tk.src_tick) |-> !st_reg.pin_s2;
   endproperty
   a_edge_sel: assert property (p_edge_sel)
      else $error("wrong pin edge counted");

   property p_edge_rise;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (st_reg.option[tmz_pkg::OPT_SRC_SEL] && !st_reg.option[tmz_pkg::OPT_EDGE_SEL]
       && tk.src_tick) |-> st_reg.pin_s2;
   endproperty
   a_edge_rise: assert property (p_edge_rise)
      else $error("falling pin edge counted");

   property p_bypass_inc;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (tk.src_tick && tk.bypass && !reg_wr_i && !$past(reg_wr_i)) |=> ##1
      (st_reg.count_value == $past(st_reg.count_value, 2) + 8'h01 || $past(reg_wr_i));
   endproperty
   a_bypass_inc: assert property (p_bypass_inc)
      else $error("bypass count missed");

   property p_master_pu;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $past(master_clear_reset_i) |-> master_clear_pullup_o;
   endproperty
   a_master_pu: assert property (p_master_pu)
      else $error("master clear pull-up dropped");

   property p_master_pu_off;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (!$past(master_clear_reset_i) && st_reg.option[tmz_pkg::OPT_PULLUP_DIS])
      |-> !master_clear_pullup_o;
   endproperty
   a_master_pu_off: assert property (p_master_pu_off)
      else $error("master clear pull-up not released");

   property p_wrap_flag;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (wrap && !tk.clear) |=> st_reg.count_value == 8'h00
      && st_reg.intctl[tmz_pkg::INT_OVF_FLAG];
   endproperty
   a_wrap_flag: assert property (p_wrap_flag)
      else $error("wrap did not set flag");

   property p_count_inc;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (tk.out_tick && !tk.clear) |=> st_reg.count_value == $past(st_reg.count_value) + 8'h01;
   endproperty
   a_count_inc: assert property (p_count_inc)
      else $error("count did not step");

   property p_count_hold;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (!tk.out_tick && !tk.clear) |=> $stable(st_reg.count_value);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("count moved without tick");

   property p_flag_hold;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (st_reg.intctl[tmz_pkg::INT_OVF_FLAG]
       && !(reg_wr_i && reg_addr_i == tmz_pkg::ADDR_INTCTL))
      |=> st_reg.intctl[tmz_pkg::INT_OVF_FLAG];
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("overflow flag lost");

   property p_irq;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      overflow_irq_o == (st_reg.intctl[tmz_pkg::INT_OVF_FLAG]
      && st_reg.intctl[tmz_pkg::INT_OVF_EN]);
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq mismatch");

   property p_rate_div4;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (tk.out_tick && !tk.bypass && tk.rate == 3'h1 && !$past(tk.clear, 1))
      |-> !$past(tk.out_tick) && !$past(tk.out_tick, 2);
   endproperty
   a_rate_div4: assert property (p_rate_div4)
      else $error("divide by four too fast");

   property p_rate_div8;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (tk.out_tick && !tk.bypass && tk.rate == 3'h2 && !$past(tk.clear, 1))
      |-> !$past(tk.out_tick) && !$past(tk.out_tick, 2) && !$past(tk.out_tick, 3);
   endproperty
   a_rate_div8: assert property (p_rate_div8)
      else $error("divide by eight too fast");
endmodule
`default_nettype wire

/* verif/tmz_pulse_src.sv */
// Purpose: External count pulse source for the timer pin
// Assumes: The pin is driven at all times and idles low
// Notes:   Edges move just after a system clock edge, so the pin stays synchronous to the block
`default_nettype none
module tmz_pulse_src (
   // Clock
   input  wire logic clk_i,
   // Pin
   output var  logic pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin_o = 1'b0;
   // Toggle n times, half period in system clocks
   task automatic toggle(input int n, input int half_cyc);
      for (int i = 0; i < n; i++) begin
         repeat (half_cyc) @(posedge clk_i);
         pin_o <= ~pin_o;
      end
   endtask
endmodule
`default_nettype wire

/* verif/tmz_timer_tb.sv */
// Purpose: Self-checking bench for the eight-bit timer
// Assumes: Read data stand one cycle after the strobe
// Notes:   Instruction clock phase is free, so timed counts allow one short
`default_nettype none
module tmz_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_sys_i = 1'b0, rst_b_i = 1'b0;
   logic [1:0] reg_addr_i = 2'h0;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d;
   logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0, master_clear_reset_i = 1'b1;
   logic       pin, master_clear_pu, pu_en, irq;
   int         fails = 0, num_checks = 0;
   tmz_pulse_src src (.clk_i(clk_sys_i), .pin_o(pin));
   tmz_timer DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .ext_count_pin_i(pin),
      .master_clear_reset_i(master_clear_reset_i), .master_clear_pullup_o(master_clear_pu),
      .pullup_enable_o(pu_en), .overflow_irq_o(irq));
   initial forever #50 clk_sys_i = ~clk_sys_i;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      @(posedge clk_sys_i);
      d = reg_rdata_o;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Accepts exp or one less
   task automatic chk_near(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp && got !== exp - 8'h01) begin
         fails++;
         $display("BAD %0t count %h near %h", $time, got, exp);
      end
   endtask
   task automatic t_reset;
      chk({5'h00, irq, master_clear_pu, pu_en}, 8'h02);
      rd(tmz_pkg::ADDR_OPTION); chk(d, tmz_pkg::OPTION_RST);
      rd(tmz_pkg::ADDR_INTCTL); chk(d, tmz_pkg::INTCTL_RST);
      rd(tmz_pkg::ADDR_COUNT); chk(d, tmz_pkg::COUNT_RST);
      rd(2'h3); chk(d, 8'h00);
   endtask
   task automatic t_instr;
      wr(tmz_pkg::ADDR_OPTION, 8'h08);
      rd(tmz_pkg::ADDR_OPTION); chk(d, 8'h08);
      wr(tmz_pkg::ADDR_COUNT, 8'h00); cyc(62);
      rd(tmz_pkg::ADDR_COUNT); chk_near(d, 8'h10);
      for (int c = 0; c < 3; c++) begin
         wr(tmz_pkg::ADDR_OPTION, 8'(c));
         wr(tmz_pkg::ADDR_COUNT, 8'h00); cyc(62);
         rd(tmz_pkg::ADDR_COUNT); chk_near(d, 8'(16 >> (c + 1)));
      end
   endtask
   task automatic t_pin(input logic [7:0] opt, input logic [7:0] e5, input logic [7:0] e6);
      wr(tmz_pkg::ADDR_OPTION, opt);
      wr(tmz_pkg::ADDR_COUNT, 8'h00);
      src.toggle(5, 3); cyc(8);
      rd(tmz_pkg::ADDR_COUNT); chk(d, e5);
      src.toggle(1, 3); cyc(8);
      rd(tmz_pkg::ADDR_COUNT); chk(d, e6);
   endtask
   task automatic t_ovf;
      wr(tmz_pkg::ADDR_INTCTL, 8'h00);
      wr(tmz_pkg::ADDR_OPTION, 8'h08);
      wr(tmz_pkg::ADDR_COUNT, 8'hfe); cyc(14);
      chk({7'h00, irq}, 8'h00);
      rd(tmz_pkg::ADDR_INTCTL); chk(d, 8'h04);
      wr(tmz_pkg::ADDR_INTCTL, 8'h24); cyc(2);
      chk({7'h00, irq}, 8'h01);
      wr(tmz_pkg::ADDR_INTCTL, 8'h20); cyc(2);
      chk({7'h00, irq}, 8'h00);
   endtask
   task automatic t_pull;
      wr(tmz_pkg::ADDR_OPTION, 8'h80); cyc(2);
      chk({6'h00, master_clear_pu, pu_en}, 8'h02);
      master_clear_reset_i <= 1'b0;
      cyc(2);
      chk({6'h00, master_clear_pu, pu_en}, 8'h00);
      wr(tmz_pkg::ADDR_OPTION, 8'h00); cyc(2);
      chk({6'h00, master_clear_pu, pu_en}, 8'h03);
      master_clear_reset_i <= 1'b1;
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #1000000;
      fails++;
      final_report;
   end
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      t_reset;
      t_instr;
      t_pin(8'h28, 8'h03, 8'h03);
      t_pin(8'h38, 8'h02, 8'h03);
      t_pin(8'h20, 8'h01, 8'h01);
      t_ovf;
      t_pull;
      final_report;
   end
endmodule
`default_nettype wire
